/* File: rtl/sdpr_bank_if.sv */
// Signals between the command decoder and one bank tracker
`default_nettype none
interface sdpr_bank_if;
   import sdpr_pkg::*;
   logic tick;
   logic act;
   logic pre;
   logic ap_arm;
   logic [7:0] ap_delay;
   logic [3:0] precharge_period;
   logic [3:0] row_active_min_time;
   sdpr_bank_st_t state;
   logic pre_noop;
   modport ctrl (output tick, act, pre, ap_arm, ap_delay, precharge_period, row_active_min_time, input state, pre_noop);
   modport bank (input tick, act, pre, ap_arm, ap_delay, precharge_period, row_active_min_time, output state, pre_noop);
endinterface
`default_nettype wire

/* File: rtl/sdpr_bank_tracker.sv */
// One bank: row state, row-active lock-out, auto precharge and precharge timers
`default_nettype none
module sdpr_bank_tracker
   import sdpr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   sdpr_bank_if.bank bus
);
   typedef struct packed {
      sdpr_bank_st_t st;
      logic [3:0] ras_cnt;
      logic [3:0] rp_cnt;
      logic ap_pend;
      logic [7:0] ap_cnt;
      logic pre_noop;
   } sdpr_bank_reg_t;

   sdpr_bank_reg_t r;
   sdpr_bank_reg_t n;
   logic ap_due;

   assign ap_due = r.ap_pend && (r.ap_cnt == 8'h00) && (r.ras_cnt == 4'h0);
   assign bus.state = r.st;
   assign bus.pre_noop = r.pre_noop;

   // ====================================================================
   // Bank state machine
   always_comb
   begin
      n = r;
      n.pre_noop = 1'b0;
      unique case (r.st)
         SDPR_IDLE:
         begin
            // [R11] no-op on idle
            if (bus.pre)
               n.pre_noop = 1'b1;
            if (bus.act)
            begin
               n.st = SDPR_ACTIVE;
               n.ras_cnt = bus.row_active_min_time;
               n.ap_pend = 1'b0;
            end
         end
         SDPR_ACTIVE:
         begin
            if (bus.tick && r.ras_cnt != 4'h0)
               n.ras_cnt = r.ras_cnt - 4'h1;
            if (bus.tick && r.ap_cnt != 8'h00)
               n.ap_cnt = r.ap_cnt - 8'h01;
            // [R13] earliest legal precharge, [R17] held until row time met
            if (bus.ap_arm)
            begin
               n.ap_pend = 1'b1;
               n.ap_cnt = bus.ap_delay;
            end
            else if (bus.pre || ap_due)
            begin
               n.st = SDPR_PRECHG;
               n.rp_cnt = bus.precharge_period;
               n.ap_pend = 1'b0;
            end
         end
         SDPR_PRECHG:
         begin
            // [R11] no-op while precharging
            if (bus.pre)
               n.pre_noop = 1'b1;
            // [R10] back to idle after precharge period
            if (bus.tick)
            begin
               if (r.rp_cnt <= 4'h1)
                  n.st = SDPR_IDLE;
               else
                  n.rp_cnt = r.rp_cnt - 4'h1;
            end
         end
         default: n.st = SDPR_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= n;
   end

   // ====================================================================
   // Checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_pre_noop_idle: assert property ( // [R11]
      (r.st == SDPR_IDLE && bus.pre && !bus.act) |=> (r.st == SDPR_IDLE && r.pre_noop))
      else $error("precharge to idle bank not ignored");
   chk_ras_lockout: assert property ( // [R17]
      (r.st == SDPR_ACTIVE && r.ras_cnt != 4'h0 && !bus.pre) |=> (r.st != SDPR_PRECHG))
      else $error("auto precharge before row active time");
   chk_ap_begin: assert property ( // [R13]
      (r.st == SDPR_ACTIVE && ap_due && !bus.ap_arm) |=> (r.st == SDPR_PRECHG))
      else $error("auto precharge did not start when due");
endmodule // sdpr_bank_tracker
`default_nettype wire

/* File: rtl/sdpr_defines.svh */
// Offsets, field positions, reset values and counts of the precharge/refresh tracker
`ifndef SDPR_DEFINES_SVH
`define SDPR_DEFINES_SVH
// ====================================================================
// Register byte offsets
`define SDPR_OFS_CTRL 8'h00
`define SDPR_OFS_TIMING 8'h04
`define SDPR_OFS_STATUS 8'h08
`define SDPR_OFS_COUNT 8'h0C
`define SDPR_OFS_REFRESH 8'h10
// ====================================================================
// Field positions and widths
`define SDPR_TIM_TRP_LSB 0
`define SDPR_TIM_ROW_ACTIVE_MIN_TIME_LSB 4
`define SDPR_TIM_TWR_LSB 8
`define SDPR_TIM_WRITE_TO_READ_DELAY_LSB 12
`define SDPR_TIM_REFRESH_CYCLE_TIME_LSB 16
`define SDPR_TIM_FW 4
`define SDPR_REFRESH_CYCLE_TIME_FW 8
`define SDPR_ST_ERR_LSB 12
`define SDPR_AP_BIT 10
`define SDPR_HSIZE_WORD 3'h2
// ====================================================================
// Reset values: burst code 1 (four elements), counts in host clock cycles
`define SDPR_CTRL_RST 2'h1
`define SDPR_TIMING_RST 24'h0C_1273
`endif

/* File: rtl/sdpr_pkg.sv */
// Types and helper functions of the precharge/refresh tracker
`default_nettype none
package sdpr_pkg;
   // Bank state, Gray along idle, active, precharging
   typedef enum logic [1:0] {SDPR_IDLE = 2'h0, SDPR_ACTIVE = 2'h1, SDPR_PRECHG = 2'h3}
      sdpr_bank_st_t;
   typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_OTHER}
      sdpr_cmd_t;

   // Command decode from the control pins
   function automatic sdpr_cmd_t sdpr_decode(input logic [4:0] c);
      sdpr_cmd_t res;
      res = CMD_OTHER;
      if (!c[4] || c[3])
         res = CMD_NOP;
      else
         case (c[2:0])
            3'h7: res = CMD_NOP;
            3'h3: res = CMD_ACT;
            3'h5: res = CMD_RD;
            3'h4: res = CMD_WR;
            3'h2: res = CMD_PRE;
            3'h1: res = CMD_REF;
            default: res = CMD_OTHER;
         endcase
      return res;
   endfunction

   // Bank select to one-hot bank vector
   function automatic logic [3:0] sdpr_onehot(input logic [1:0] b);
      return 4'h1 << b;
   endfunction

   // Number of set bits in a nibble
   function automatic logic [2:0] sdpr_ones(input logic [3:0] v);
      return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
   endfunction

   // Data pairs of a burst from the burst code
   function automatic logic [4:0] sdpr_bl_pairs(input logic [1:0] code);
      return 5'h01 << code;
   endfunction
endpackage
`default_nettype wire

/* File: rtl/sdpr_precharge_refresh.sv */
// Device-side precharge, write recovery and auto refresh tracker with AHB-Lite registers
//
// What this block does
// [R1] Early read to another device is the host's choice; one device here.
// [R2] Write-to-read and recovery timers start on edge after last data pair.
// [R3] Early precharge to another device is the host's choice.
// [R4] Host toggles strobe through masked beats of an interrupted write.
// [R5] Burst of four cut by precharge needs no strobe past four.
// [R6] Write bursts of two, four, eight or sixteen elements.
// [R7] Back-to-back writes to any bank are accepted.
// [R8] Precharge closes the selected bank, or all banks with bit ten high.
// [R9] Host waits the precharge period before activating again.
// [R10] Precharged bank goes idle; access needs a fresh activate.
// [R11] Precharge to idle or precharging bank is a no-op.
// [R12] Bit ten on each read or write selects auto precharge, not kept.
// [R13] Auto precharge starts at the earliest legal explicit precharge point.
// [R14] Write auto precharge starts when write recovery ends.
// [R15] Host gives at least one clock during write recovery.
// [R16] Host sends nothing to an auto-precharging bank until it is done.
// [R17] Auto precharge waits for the minimum row active time.
// [R18] Other banks take commands during an auto precharge.
// [R19] Each auto refresh command performs one refresh.
// [R20] Refresh row comes from an internal counter; address ignored.
// [R21] Refresh lasts the refresh cycle time from its command.
// [R22] Read auto precharge starts half a burst after the read.
// [R23] Masked write elements are not written.
// [R24] Only no-op with clock enable high during refresh.
// [R25] Host schedules refreshes and precharges all banks first.
// [R26] Each bank keeps its own state and timers.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`default_nettype none
`include "sdpr_defines.svh"

module sdpr_precharge_refresh
   import sdpr_pkg::*;
#(
   parameter int ADDR_W = 13
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic dram_ck,
   input wire logic dram_cke,
   input wire logic dram_cs_n,
   input wire logic dram_ras_n,
   input wire logic dram_cas_n,
   input wire logic dram_we_n,
   input wire logic [ADDR_W-1:0] dram_addr,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [1:0] write_data_mask,
   input wire logic [1:0] dram_dqs
);
   localparam int NB = 4;
   localparam int PW = ADDR_W + 12;

   typedef struct packed {
      logic [PW-1:0] sy1;
      logic [PW-1:0] sy2;
      logic ck_d;
      logic dqs_d;
      logic [1:0] bl;
      logic [23:0] timing;
      logic [4:0] wr_left;
      logic [3:0] wtr_cnt;
      logic [3:0] wr_rec;
      logic [7:0] rfc_cnt;
      logic [15:0] ref_row;
      logic [15:0] wr_elem;
      logic [15:0] mask_elem;
      logic [7:0] noop_cnt;
      logic [1:0] err;
      logic a_vld;
      logic a_write;
      logic [7:0] a_ofs;
      logic [31:0] hrdata;
      logic hready;
   } sdpr_top_st_t;

   sdpr_top_st_t r;
   sdpr_top_st_t n;
   logic [PW-1:0] pin_in;
   logic cke_s;
   logic cs_n_s;
   logic ras_n_s;
   logic cas_n_s;
   logic we_n_s;
   logic [1:0] ba_s;
   logic [ADDR_W-1:0] addr_s;
   logic [1:0] dm_s;
   logic [1:0] dqs_s;
   logic ck_s;
   logic tick;
   logic dq_edge;
   logic addr_bit_ten_precharge_sel;
   sdpr_cmd_t cmd;
   logic trunc;
   logic a_go;
   logic [4:0] pairs;
   logic [4:0] wr_first;
   logic [3:0] trp_w;
   logic [3:0] row_active_min_time_w;
   logic [3:0] twr_w;
   logic [3:0] write_to_read_delay_w;
   logic [7:0] refresh_cycle_time_w;
   logic [3:0] act_v;
   logic [3:0] pre_v;
   logic [3:0] arm_v;
   logic [3:0] noop_v;
   logic [7:0] ap_dly;
   logic [7:0] st_flat;
   logic [31:0] status_w;
   sdpr_bank_st_t st_v [NB];

   // ====================================================================
   // Pin capture and host clock edges
   assign pin_in = {dram_cke, dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n,
                    bank_select_high, bank_select_low, dram_addr, write_data_mask,
                    dram_dqs, dram_ck};
   assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, dm_s, dqs_s, ck_s} = r.sy2;
   assign tick = ck_s & ~r.ck_d;
   assign dq_edge = dqs_s[0] ^ r.dqs_d;
   assign addr_bit_ten_precharge_sel = addr_s[`SDPR_AP_BIT];
   assign cmd = tick ? sdpr_decode({cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s}) : CMD_NOP;
   assign trunc = (cmd == CMD_RD || cmd == CMD_PRE) && (r.wr_left != 5'h00);

   // Timing fields in host clock cycles
   assign trp_w = r.timing[`SDPR_TIM_TRP_LSB +: `SDPR_TIM_FW];
   assign row_active_min_time_w = r.timing[`SDPR_TIM_ROW_ACTIVE_MIN_TIME_LSB +: `SDPR_TIM_FW];
   assign twr_w = r.timing[`SDPR_TIM_TWR_LSB +: `SDPR_TIM_FW];
   assign write_to_read_delay_w = r.timing[`SDPR_TIM_WRITE_TO_READ_DELAY_LSB +: `SDPR_TIM_FW];
   assign refresh_cycle_time_w = r.timing[`SDPR_TIM_REFRESH_CYCLE_TIME_LSB +: `SDPR_REFRESH_CYCLE_TIME_FW];
   // [R6] burst of two to sixteen elements, in pairs
   assign pairs = sdpr_bl_pairs(r.bl);
   assign wr_first = pairs + 5'h01;

   // ====================================================================
   // Per-bank command steering
   assign act_v = (cmd == CMD_ACT) ? sdpr_onehot(ba_s) : 4'h0;
   // [R8] single bank or all banks
   assign pre_v = (cmd != CMD_PRE) ? 4'h0 :
                  (addr_bit_ten_precharge_sel ? 4'hF : sdpr_onehot(ba_s));
   // [R12] auto precharge chosen per command
   assign arm_v = ((cmd == CMD_RD || cmd == CMD_WR) && addr_bit_ten_precharge_sel) ?
                  sdpr_onehot(ba_s) : 4'h0;
   // [R14] write recovery after last pair, [R22] half a burst for reads
   assign ap_dly = (cmd == CMD_WR) ? ({3'h0, pairs} + {4'h0, twr_w} + 8'h01) : {3'h0, pairs};

   // [R26] independent tracker per bank, [R18] other banks stay free
   sdpr_bank_if bif [NB] ();
   for (genvar g = 0; g < NB; g++)
   begin : g_bank
      assign bif[g].tick = tick;
      assign bif[g].act = act_v[g];
      assign bif[g].pre = pre_v[g];
      assign bif[g].ap_arm = arm_v[g];
      assign bif[g].ap_delay = ap_dly;
      assign bif[g].precharge_period = trp_w;
      assign bif[g].row_active_min_time = row_active_min_time_w;
      assign st_v[g] = bif[g].state;
      assign noop_v[g] = bif[g].pre_noop;
      assign st_flat[2*g +: 2] = bif[g].state;
      sdpr_bank_tracker u_bank (
         .sys_clk(sys_clk),
         .rst(rst),
         .bus(bif[g])
      );
   end

   // ====================================================================
   // Bus slave and status
   assign a_go = hsel && hready && htrans[1] && (hsize == `SDPR_HSIZE_WORD);
   assign status_w = {18'h0, r.err, (r.wr_left != 5'h00), (r.wr_rec != 4'h0),
                      (r.wtr_cnt != 4'h0), (r.rfc_cnt != 8'h00), st_flat};
   assign hreadyout = r.hready;
   assign hresp = 1'b0;
   assign hrdata = r.hrdata;

   // ====================================================================
   // Next-state logic
   always_comb
   begin
      logic [31:0] rd_val;
      rd_val = 32'h0000_0000;
      n = r;
      // Two-stage synchronisers, then edge history
      n.sy1 = pin_in;
      n.sy2 = r.sy1;
      n.ck_d = ck_s;
      n.dqs_d = dqs_s[0];

      // Read data is captured in the address phase
      case (haddr[7:0])
         `SDPR_OFS_CTRL: rd_val = {30'h0, r.bl};
         `SDPR_OFS_TIMING: rd_val = {8'h00, r.timing};
         `SDPR_OFS_STATUS: rd_val = status_w;
         `SDPR_OFS_COUNT: rd_val = {r.mask_elem, r.wr_elem};
         `SDPR_OFS_REFRESH: rd_val = {8'h00, r.noop_cnt, r.ref_row};
         default: rd_val = 32'h0000_0000;
      endcase
      n.a_vld = a_go;
      n.a_write = hwrite;
      n.a_ofs = haddr[7:0];
      if (a_go && !hwrite)
         n.hrdata = rd_val;

      // Data-phase writes; error bits clear on writing one
      if (r.a_vld && r.a_write)
      begin
         case (r.a_ofs)
            `SDPR_OFS_CTRL: n.bl = hwdata[1:0];
            `SDPR_OFS_TIMING: n.timing = hwdata[23:0];
            `SDPR_OFS_STATUS: n.err = r.err & ~hwdata[`SDPR_ST_ERR_LSB +: 2];
            default: n.err = r.err;
         endcase
      end

      // [R2] recovery timers load on the edge after the last pair
      if (tick)
      begin
         if (r.wtr_cnt != 4'h0)
            n.wtr_cnt = r.wtr_cnt - 4'h1;
         if (r.wr_rec != 4'h0)
            n.wr_rec = r.wr_rec - 4'h1;
         if (r.wr_left != 5'h00)
         begin
            n.wr_left = r.wr_left - 5'h01;
            if (r.wr_left == 5'h01)
            begin
               n.wtr_cnt = write_to_read_delay_w;
               n.wr_rec = twr_w;
            end
         end
      end
      // [R7] every write restarts the burst window
      if (cmd == CMD_WR)
         n.wr_left = wr_first;
      else if (trunc)
      begin
         // Interrupted burst: timers start at once
         n.wr_left = 5'h00;
         n.wtr_cnt = write_to_read_delay_w;
         n.wr_rec = twr_w;
      end

      // [R23] masked elements counted apart from written ones
      if (dq_edge && r.wr_left != 5'h00)
      begin
         n.wr_elem = r.wr_elem + {13'h0, sdpr_ones({2'h0, ~dm_s})};
         n.mask_elem = r.mask_elem + {13'h0, sdpr_ones({2'h0, dm_s})};
      end

      // [R20] internal row counter, [R21] busy for the refresh cycle time
      if (cmd == CMD_REF)
      begin
         n.rfc_cnt = refresh_cycle_time_w;
         n.ref_row = r.ref_row + 16'h0001;
      end
      else if (tick && r.rfc_cnt != 8'h00)
         n.rfc_cnt = r.rfc_cnt - 8'h01;

      // [R11] ignored precharges counted
      n.noop_cnt = r.noop_cnt + {5'h00, sdpr_ones(noop_v)};

      // [R10] access to a bank without an open row
      if ((cmd == CMD_RD || cmd == CMD_WR) && st_v[ba_s] != SDPR_ACTIVE)
         n.err[0] = 1'b1;
      // [R24] command or low clock enable during refresh
      if (tick && r.rfc_cnt != 8'h00 && (cmd != CMD_NOP || !cke_s))
         n.err[1] = 1'b1;
   end

   // State register
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         r <= '0;
         r.bl <= `SDPR_CTRL_RST;
         r.timing <= `SDPR_TIMING_RST;
         r.hready <= 1'b1;
      end
      else
         r <= n;
   end

   // ====================================================================
   // Checks
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_ref_start: assert property ( // [R21]
      (cmd == CMD_REF) |=> (r.rfc_cnt == $past(refresh_cycle_time_w)))
      else $error("refresh timer not loaded");
   chk_ref_row_inc: assert property ( // [R20]
      (cmd == CMD_REF) |=> (r.ref_row == $past(r.ref_row) + 16'h0001))
      else $error("refresh row not advanced");
   chk_ref_hold: assert property ( // [R21]
      (r.rfc_cnt != 8'h00 && !tick) |=> (r.rfc_cnt == $past(r.rfc_cnt)))
      else $error("refresh timer moved without host clock");
   chk_pre_all_banks: assert property ( // [R8]
      (cmd == CMD_PRE && addr_bit_ten_precharge_sel) |-> (pre_v == 4'hF))
      else $error("all-bank precharge missed a bank");
   chk_pre_one_bank: assert property ( // [R8]
      (cmd == CMD_PRE && !addr_bit_ten_precharge_sel)
         |-> (pre_v[ba_s] && sdpr_ones(pre_v) == 3'h1))
      else $error("single precharge hit wrong bank");
   chk_ap_none: assert property ( // [R12]
      ((cmd == CMD_RD || cmd == CMD_WR) && !addr_bit_ten_precharge_sel) |-> (arm_v == 4'h0))
      else $error("auto precharge armed with bit ten low");
   chk_ap_read_delay: assert property ( // [R22]
      (cmd == CMD_RD && addr_bit_ten_precharge_sel)
         |-> (arm_v[ba_s] && ap_dly == (8'h01 << r.bl)))
      else $error("read auto precharge delay wrong");
   chk_ap_write_delay: assert property ( // [R14]
      (cmd == CMD_WR && addr_bit_ten_precharge_sel)
         |-> (ap_dly == (8'h01 << r.bl) + 8'h01
              + {4'h0, r.timing[`SDPR_TIM_TWR_LSB +: `SDPR_TIM_FW]}))
      else $error("write auto precharge delay wrong");
   chk_wr_window: assert property ( // [R7]
      (cmd == CMD_WR) |=> (r.wr_left == $past(wr_first)))
      else $error("write burst window not restarted");
   chk_rec_start: assert property ( // [R2]
      (tick && r.wr_left == 5'h01 && cmd != CMD_WR && !trunc)
         |=> (r.wr_rec == $past(twr_w) && r.wtr_cnt == $past(write_to_read_delay_w)))
      else $error("recovery timers not started after last pair");
   chk_mask_skip: assert property ( // [R23]
      (dq_edge && r.wr_left != 5'h00 && dm_s == 2'h3) |=> (r.wr_elem == $past(r.wr_elem)))
      else $error("masked element counted as written");
   chk_err_idle: assert property ( // [R10]
      ((cmd == CMD_RD || cmd == CMD_WR) && st_v[ba_s] != SDPR_ACTIVE) |=> r.err[0])
      else $error("access to closed bank not flagged");

   cov_refresh: cover property (cmd == CMD_REF);
   cov_ap_read: cover property (cmd == CMD_RD && addr_bit_ten_precharge_sel);
   cov_trunc: cover property (trunc);
   cov_pre_noop: cover property (noop_v != 4'h0);
endmodule // sdpr_precharge_refresh
`default_nettype wire

/* File: tb/sdpr_host_model.sv */
// Host memory controller model driving command, mask and strobe pins
`default_nettype none
module sdpr_host_model
(
   output logic dram_ck,
   output logic dram_cke,
   output logic dram_cs_n,
   output logic dram_ras_n,
   output logic dram_cas_n,
   output logic dram_we_n,
   output logic [12:0] dram_addr,
   output logic bank_select_low,
   output logic bank_select_high,
   output logic [1:0] write_data_mask,
   output logic [1:0] dram_dqs
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================================================================
   // Idle pins and free-running host clock, phase offset from sys_clk
   // clock runs, enable high
   initial
   begin
      {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n, dram_cke} = 5'h1F;
      dram_ck = 1'b0;
      dram_addr = 13'h0000;
      {bank_select_high, bank_select_low} = 2'h0;
      write_data_mask = 2'h0;
      dram_dqs = 2'h0;
      #1.3;
      forever #80 dram_ck = ~dram_ck;
   end
   // One command, held across one rising edge, deselected a quarter cycle later
   // one device only, so reads and precharges keep the full spacing
   task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a);
      dram_cs_n = 1'b0;
      {dram_ras_n, dram_cas_n, dram_we_n} = rcw;
      dram_addr = a;
      {bank_select_high, bank_select_low} = b;
      @(posedge dram_ck);
      #40;
      dram_cs_n = 1'b1;
      {dram_ras_n, dram_cas_n, dram_we_n} = 3'h7;
      dram_addr = ~a;
      {bank_select_high, bank_select_low} = ~b;
      @(negedge dram_ck);
   endtask
   // strobe all four elements, masked ones too, none past four
   task automatic wr_data(input logic [7:0] m);
      for (int i = 0; i < 4; i++)
      begin
         #40 write_data_mask = m[2*i +: 2];
         #40 dram_dqs = ~dram_dqs;
      end
      #40 write_data_mask = ~write_data_mask;
   endtask
endmodule // sdpr_host_model
`default_nettype wire

/* File: tb/sdpr_precharge_refresh_tb.sv */
// Self-checking bench of the precharge and refresh tracker
`default_nettype none
module sdpr_precharge_refresh_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] c_act = 3'h3;
   localparam logic [2:0] c_rd = 3'h5;
   localparam logic [2:0] c_wr = 3'h4;
   localparam logic [2:0] c_pre = 3'h2;
   localparam logic [2:0] c_ref = 3'h1;
   logic sys_clk, rst, hsel, hwrite;
   logic rd_pend = 1'b0;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, mk;
   logic [63:0] ent;
   logic [63:0] expq[$];
   logic [31:0] rstv [6] = '{32'h0000_0001, 32'h000C_1273, 32'h0, 32'h0, 32'h0, 32'h0};
   wire logic hreadyout, hresp, dram_ck, dram_cke, dram_cs_n, dram_ras_n, dram_cas_n;
   wire logic dram_we_n, bank_select_low, bank_select_high;
   wire logic [31:0] hrdata;
   wire logic [12:0] dram_addr;
   wire logic [1:0] write_data_mask, dram_dqs;
   int num_errors = 0;
   int total_checks = 0;
   integer seed = 23692;
   // ====================================================================
   // Instances
   sdpr_precharge_refresh #(.ADDR_W(13)) u_sdpr_precharge_refresh (.sys_clk(sys_clk),
      .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .dram_ck(dram_ck), .dram_cke(dram_cke),
      .dram_cs_n(dram_cs_n), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n),
      .dram_we_n(dram_we_n), .dram_addr(dram_addr), .bank_select_low(bank_select_low),
      .bank_select_high(bank_select_high), .write_data_mask(write_data_mask),
      .dram_dqs(dram_dqs));
   sdpr_host_model u_sdpr_host_model (.dram_ck(dram_ck), .dram_cke(dram_cke),
      .dram_cs_n(dram_cs_n), .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n),
      .dram_we_n(dram_we_n), .dram_addr(dram_addr), .bank_select_low(bank_select_low),
      .bank_select_high(bank_select_high), .write_data_mask(write_data_mask),
      .dram_dqs(dram_dqs));
   // ====================================================================
   // Clock, checking and bus tasks
   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Single transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
   endtask
   // Read with expected value noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      expq.push_back({e, m});
      ahb(1'b0, a, $random(seed));
   endtask
   task automatic nop(input int n);
      repeat (n) @(negedge dram_ck);
   endtask
   // Monitor takes the oldest note when read data stands
   always @(posedge sys_clk)
   begin
      if (rd_pend && hreadyout === 1'b1)
      begin
         ent = expq.pop_front();
         check(hrdata & ent[31:0], ent[63:32]);
         check({30'h0, hresp, hreadyout}, 32'h0000_0001);
      end
      rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
   end
   // Watchdog
   initial
   begin
      #200000;
      num_errors++;
      finish_test();
   end
   // ====================================================================
   // Main sequence
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      rst = 1'b1;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      ahb(1'b1, 8'h14, $random(seed));
      ahb(1'b1, 8'h0C, $random(seed));
      for (int i = 0; i < 6; i++)
         rd(8'(4 * i), 32'hFFFF_FFFF, rstv[i]);
      for (int i = 0; i < 4; i++)
      begin
         ahb(1'b1, 8'h00, (32'($random(seed)) & 32'hFFFF_FFFC) | 32'(i));
         rd(8'h00, 32'h0000_0003, 32'(i));
      end
      ahb(1'b1, 8'h00, 32'h0000_0001);
      ahb(1'b1, 8'h04, 32'h0005_1262);
      rd(8'h04, 32'hFFFF_FFFF, 32'h0005_1262);
      @(negedge dram_ck);
      // auto precharge write then read, bank left alone
      for (int k = 0; k < 2; k++)
      begin
         mk = 32'h0000_0003 << (2 * k);
         u_sdpr_host_model.cmd(c_act, 2'(k), 13'h0000);
         u_sdpr_host_model.cmd(k ? c_rd : c_wr, 2'(k), 13'h0400);
         if (k == 0)
         begin
            u_sdpr_host_model.wr_data(8'h34);
            nop(1);
            rd(8'h08, 32'h0000_0603, 32'h0000_0601);
         end
         else
         begin
            nop(3);
            rd(8'h08, 32'h0000_000C, 32'h0000_0004);
         end
         nop(3);
         rd(8'h08, mk, mk);
         nop(3);
         rd(8'h08, mk, 32'h0);
      end
      rd(8'h0C, 32'hFFFF_FFFF, 32'h0003_0005);
      u_sdpr_host_model.cmd(c_act, 2'h1, 13'h0000);
      u_sdpr_host_model.cmd(c_rd, 2'h1, 13'h0000);
      nop(9);
      rd(8'h08, 32'h0000_000C, 32'h0000_0004);
      // single bank, repeated and all-bank precharge
      u_sdpr_host_model.cmd(c_act, 2'h2, 13'h0000);
      u_sdpr_host_model.cmd(c_pre, 2'h2, 13'h0000);
      rd(8'h08, 32'h0000_003C, 32'h0000_0034);
      u_sdpr_host_model.cmd(c_pre, 2'h2, 13'h0000);
      nop(3);
      rd(8'h08, 32'h0000_003C, 32'h0000_0004);
      u_sdpr_host_model.cmd(c_pre, 2'h2, 13'h0000);
      rd(8'h10, 32'h00FF_0000, 32'h0002_0000);
      u_sdpr_host_model.cmd(c_pre, 2'($random(seed)), 13'h0400);
      rd(8'h08, 32'h0000_00FF, 32'h0000_000C);
      nop(3);
      rd(8'h08, 32'h0000_00FF, 32'h0000_0000);
      // each command is one refresh, address ignored
      for (int i = 1; i < 3; i++)
      begin
         u_sdpr_host_model.cmd(c_ref, 2'($random(seed)), 13'($random(seed)));
         rd(8'h08, 32'h0000_0100, 32'h0000_0100);
         if (i == 2)
            u_sdpr_host_model.cmd(c_act, 2'h0, 13'h0000);
         nop(5);
         rd(8'h08, 32'h0000_0100, 32'h0000_0000);
         rd(8'h10, 32'h0000_FFFF, 32'(i));
      end
      u_sdpr_host_model.cmd(c_wr, 2'h0, 13'h0000);
      // precharge cuts the write, strobe runs on through masked beats
      fork
         u_sdpr_host_model.wr_data(8'hF0);
         u_sdpr_host_model.cmd(c_pre, 2'h0, 13'h0000);
      join
      rd(8'h08, 32'h0000_0F03, 32'h0000_0403);
      u_sdpr_host_model.cmd(c_rd, 2'h3, 13'h0000);
      rd(8'h08, 32'h0000_3000, 32'h0000_3000);
      ahb(1'b1, 8'h08, 32'h0000_3000);
      rd(8'h08, 32'h0000_3000, 32'h0000_0000);
      @(posedge sys_clk);
      finish_test();
   end
endmodule // sdpr_precharge_refresh_tb
`default_nettype wire
